//--- design/asp_pkg.sv
// Constants, register map and types for the multiprocessor async serial port
// How it works
// - Address-bit mode adds one bit after data: 1 first frame, 0 later.
// - Buffer-to-shifter move copies wake request to temp flag, then clears request.
// - Buffer and wake request accept writes once shifter and temp flag load.
// - Frame: start, one to eight data, optional parity, one or two stops.
// - Every bit lasts exactly eight sample ticks.
// - Start accepted after four low ticks in a row; high restarts search.
// - Bits sampled at ticks four, five, six; two-of-three majority decides.
// - Control one bit 0 enables receiver, bit 1 enables transmitter.
// - Complete frame moves to rx buffer, sets ready (status bit 6), requests interrupt.
// - Reading rx buffer clears receive-ready.
// - Receiver disabled: keep assembling, never update rx buffer.
// - Tx buffer write drops tx ready; move to shifter raises it, interrupts.
// - Clearing transmitter enable lets the current character finish.
// - Last character done and buffer empty shows transmitter empty.
// - Receive error is OR of framing, overrun, break and parity errors.
// - Disabled interrupts are suppressed; flags keep updating.
// - Separate rx and tx requests with priority; rx wins ties.
// - Line low 9.625 bits after missing stop sets break (status bit 5).
// - Ready and break gated by control two bit 1; errors by control one bit 6.
// - Each buffer-to-shifter move sets tx ready (bit 7) and tx interrupt; a tx buffer write in the same cycle keeps them clear.
// - Bit clock from 16-bit divisor; top rate is clock over sixteen.
// - Sleep set: no flags or interrupts unless frame address bit is 1.
// - Comm control: 2-0 length, 3 address mode, 5 parity, 6 even, 7 two stops.
`default_nettype none
package asp_pkg;
	// ----------------------------------------
	// Register indices (byte address is index times four)
	// ----------------------------------------
	localparam logic [3:0] REG_CCR = 4'h0;
	localparam logic [3:0] REG_CTL1 = 4'h1;
	localparam logic [3:0] REG_HBAUD = 4'h2;
	localparam logic [3:0] REG_LBAUD = 4'h3;
	localparam logic [3:0] REG_CTL2 = 4'h4;
	localparam logic [3:0] REG_RXST = 4'h5;
	localparam logic [3:0] REG_RXBUF = 4'h7;
	localparam logic [3:0] REG_TXBUF = 4'h9;
	localparam logic [3:0] REG_PRIO = 4'hF;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL1_RX_ON = 0;
	localparam int CTL1_TX_ON = 1;
	localparam int CTL1_SLEEP = 2;
	localparam int CTL1_WAKE_REQ = 3;
	localparam int CTL1_ERRIE = 6;
	localparam int CTL2_TXIE = 0;
	localparam int CTL2_RXIE = 1;
	localparam int RXST_WAKE = 1;
	localparam int RXST_PARITY = 2;
	localparam int RXST_OE = 3;
	localparam int RXST_FRAMING = 4;
	localparam int RXST_BRK = 5;
	localparam int PRIO_RX = 0;
	localparam int PRIO_TX = 1;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] CCR_RESET = 8'h07;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [2:0] LAST_TICK = 3'h7;
	localparam logic [1:0] START_LOW_LAST = 2'h3;
	localparam logic [2:0] SAMPLE_A = 3'h3;
	localparam logic [2:0] SAMPLE_B = 3'h4;
	localparam logic [2:0] SAMPLE_C = 3'h5;
	localparam logic [2:0] START_RESUME = 3'h4;
	localparam int TICKS_PER_BIT = 8;
	localparam int BREAK_MILLIBITS = 9625;
	localparam int BREAK_TICKS = (BREAK_MILLIBITS * TICKS_PER_BIT + 999) / 1000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic stop2;
		logic even;
		logic par_en;
		logic spare;
		logic mp_mode;
		logic [2:0] char_length_field;
	} asp_ccr_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_ADDR, TX_PARITY, TX_STOP1, TX_STOP2} asp_tx_state_type;
	typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_ADDR, RX_PARITY, RX_STOP, RX_BREAK} asp_rx_state_type;
endpackage
`default_nettype wire

//--- design/asp_serial_port.sv
// Multiprocessor async serial port with APB register access
//
// Added by the designer: the register addresses and the APB interface to the registers.
`default_nettype none
module asp_serial_port import asp_pkg::*; #(
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line
	input wire logic rx_data_pin,
	output logic tx_data_pin,
	// Interrupt requests
	output logic rx_irq,
	output logic tx_irq,
	output logic rx_irq_high_pri,
	output logic tx_irq_high_pri,
	output logic grant_rx,
	output logic grant_tx
);
	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[5:2];
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic [3:0] i;
		i = a[5:2];
		if (a[1:0] != 2'h0 || (a >> 6) != '0) begin
			return 1'b0;
		end else if (i == REG_CCR || i == REG_CTL1 || i == REG_HBAUD || i == REG_LBAUD) begin
			return 1'b1;
		end else if (i == REG_CTL2 || i == REG_RXST || i == REG_RXBUF || i == REG_TXBUF) begin
			return 1'b1;
		end else begin
			return i == REG_PRIO;
		end
	endfunction

	function automatic logic [7:0] char_mask(input logic [2:0] len);
		return 8'hFF >> (3'h7 - len);
	endfunction

	logic access;
	logic wr;
	logic rd;
	assign access = psel & penable & is_mapped(paddr);
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~is_mapped(paddr);

	logic ccr_wr, ctl1_wr, txbuf_wr, rxbuf_rd, rxst_wr;
	assign ccr_wr = wr && reg_index(paddr) == REG_CCR;
	assign ctl1_wr = wr && reg_index(paddr) == REG_CTL1;
	assign txbuf_wr = wr && reg_index(paddr) == REG_TXBUF;
	assign rxst_wr = wr && reg_index(paddr) == REG_RXST;
	assign rxbuf_rd = rd && reg_index(paddr) == REG_RXBUF;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	asp_ccr_type ccr;
	logic receiver_enable_bit, transmitter_enable_bit, sleep_bit, rx_err_irq_enable;
	logic rx_break_irq_enable, tx_irq_enable, rx_hi, tx_hi;
	logic [7:0] baud_hi, baud_lo;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccr <= asp_ccr_type'(CCR_RESET);
			receiver_enable_bit <= 1'b0;
			transmitter_enable_bit <= 1'b0;
			sleep_bit <= 1'b0;
			rx_err_irq_enable <= 1'b0;
			rx_break_irq_enable <= 1'b0;
			tx_irq_enable <= 1'b0;
			rx_hi <= 1'b0;
			tx_hi <= 1'b0;
			baud_hi <= BAUD_RESET;
			baud_lo <= BAUD_RESET;
		end else if (wr) begin
			if (ccr_wr) begin
				ccr <= asp_ccr_type'(pwdata[7:0]);
			end else if (ctl1_wr) begin
				receiver_enable_bit <= pwdata[CTL1_RX_ON];
				transmitter_enable_bit <= pwdata[CTL1_TX_ON];
				sleep_bit <= pwdata[CTL1_SLEEP];
				rx_err_irq_enable <= pwdata[CTL1_ERRIE];
			end else if (reg_index(paddr) == REG_HBAUD) begin
				baud_hi <= pwdata[7:0];
			end else if (reg_index(paddr) == REG_LBAUD) begin
				baud_lo <= pwdata[7:0];
			end else if (reg_index(paddr) == REG_CTL2) begin
				tx_irq_enable <= pwdata[CTL2_TXIE];
				rx_break_irq_enable <= pwdata[CTL2_RXIE];
			end else if (reg_index(paddr) == REG_PRIO) begin
				rx_hi <= pwdata[PRIO_RX];
				tx_hi <= pwdata[PRIO_TX];
			end
		end
	end

	// ----------------------------------------
	// Baud divider: one tick per eighth of a bit
	// ----------------------------------------
	// Divisor zero is treated as one so a bit never runs faster than clock/16
	logic [15:0] baud_divisor, div_last, div_cnt;
	logic baud_tick;
	assign baud_divisor = {baud_hi, baud_lo};
	assign div_last = (baud_divisor == 16'h0000) ? 16'h0001 : baud_divisor;
	assign baud_tick = div_cnt == div_last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 16'h0000;
		end else if (baud_tick) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	asp_tx_state_type tx_state;
	logic [7:0] tx_buffer, tx_shift_register;
	logic tx_buf_full, tx_wake_request, wake_temp_flag, tx_par;
	logic [2:0] tx_tick_cnt, tx_bit_cnt;
	logic tx_load, tx_bit_end, tx_ready_flag, tx_empty, tx_line;
	assign tx_load = tx_state == TX_IDLE && tx_buf_full && transmitter_enable_bit;
	assign tx_bit_end = baud_tick && tx_state != TX_IDLE && tx_tick_cnt == LAST_TICK;
	assign tx_ready_flag = ~tx_buf_full;
	assign tx_empty = ~tx_buf_full && tx_state == TX_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buffer <= 8'h00;
			tx_buf_full <= 1'b0;
		end else if (txbuf_wr) begin
			tx_buffer <= pwdata[7:0] & char_mask(ccr.char_length_field);
			tx_buf_full <= 1'b1;
		end else if (tx_load) begin
			tx_buf_full <= 1'b0;
		end
	end

	// A wake request written in the load cycle survives for the next frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wake_request <= 1'b0;
		end else if (ctl1_wr) begin
			tx_wake_request <= pwdata[CTL1_WAKE_REQ];
		end else if (tx_load) begin
			tx_wake_request <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TX_IDLE;
			tx_shift_register <= 8'h00;
			wake_temp_flag <= 1'b0;
			tx_par <= 1'b0;
			tx_tick_cnt <= 3'h0;
			tx_bit_cnt <= 3'h0;
		end else if (tx_load) begin
			tx_shift_register <= tx_buffer;
			wake_temp_flag <= tx_wake_request;
			tx_par <= ^tx_buffer ^ (ccr.mp_mode & tx_wake_request) ^ ~ccr.even;
			tx_tick_cnt <= 3'h0;
			tx_bit_cnt <= 3'h0;
			tx_state <= TX_START;
		end else if (baud_tick && tx_state != TX_IDLE) begin
			tx_tick_cnt <= tx_tick_cnt + 3'h1;
			if (tx_bit_end) begin
				case (tx_state)
					TX_START: begin
						tx_state <= TX_DATA;
					end
					TX_DATA: begin
						tx_shift_register <= tx_shift_register >> 1;
						tx_bit_cnt <= tx_bit_cnt + 3'h1;
						if (tx_bit_cnt == ccr.char_length_field) begin
							tx_state <= ccr.mp_mode ? TX_ADDR : (ccr.par_en ? TX_PARITY : TX_STOP1);
						end
					end
					TX_ADDR: begin
						tx_state <= ccr.par_en ? TX_PARITY : TX_STOP1;
					end
					TX_PARITY: begin
						tx_state <= TX_STOP1;
					end
					TX_STOP1: begin
						tx_state <= ccr.stop2 ? TX_STOP2 : TX_IDLE;
					end
					default: begin
						tx_state <= TX_IDLE;
					end
				endcase
			end
		end
	end

	always_comb begin
		case (tx_state)
			TX_START: tx_line = 1'b0;
			TX_DATA: tx_line = tx_shift_register[0];
			TX_ADDR: tx_line = wake_temp_flag;
			TX_PARITY: tx_line = tx_par;
			default: tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_pin <= 1'b1;
		end else begin
			tx_data_pin <= tx_line;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	asp_rx_state_type rx_state;
	logic [7:0] rx_shift_register, rx_buffer;
	logic [2:0] rx_tick_cnt, rx_bit_cnt;
	logic [1:0] low_cnt;
	logic [6:0] break_cnt;
	logic samp_a, samp_b, maj, decide, rx_par, rx_addr_bit, par_bad;
	logic frame_done, rx_commit, stop_ok;
	logic rx_ready_flag, break_detect_flag, framing_error_flag, parity_error_flag, overrun_flag, rx_wake_flag;
	logic rx_error;
	assign maj = (samp_a & samp_b) | (samp_a & rx_data_pin) | (samp_b & rx_data_pin);
	assign decide = baud_tick && rx_tick_cnt == SAMPLE_C;
	assign frame_done = decide && rx_state == RX_STOP;
	assign stop_ok = maj;
	// Sleep keeps the receiver running but hides every non-address frame
	assign rx_commit = frame_done && receiver_enable_bit
		&& (!sleep_bit || (ccr.mp_mode && rx_addr_bit));
	assign rx_error = framing_error_flag | overrun_flag | break_detect_flag | parity_error_flag;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_a <= 1'b1;
			samp_b <= 1'b1;
		end else if (baud_tick && rx_tick_cnt == SAMPLE_A) begin
			samp_a <= rx_data_pin;
		end else if (baud_tick && rx_tick_cnt == SAMPLE_B) begin
			samp_b <= rx_data_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RX_HUNT;
			rx_shift_register <= 8'h00;
			rx_tick_cnt <= 3'h0;
			rx_bit_cnt <= 3'h0;
			low_cnt <= 2'h0;
			break_cnt <= 7'h00;
			rx_par <= 1'b0;
			rx_addr_bit <= 1'b0;
			par_bad <= 1'b0;
		end else if (baud_tick) begin
			rx_tick_cnt <= rx_tick_cnt + 3'h1;
			case (rx_state)
				RX_HUNT: begin
					if (rx_data_pin) begin
						low_cnt <= 2'h0;
					end else if (low_cnt == START_LOW_LAST) begin
						low_cnt <= 2'h0;
						rx_tick_cnt <= START_RESUME;
						rx_bit_cnt <= 3'h0;
						rx_par <= 1'b0;
						rx_addr_bit <= 1'b0;
						par_bad <= 1'b0;
						rx_state <= RX_START;
					end else begin
						low_cnt <= low_cnt + 2'h1;
					end
				end
				RX_START: begin
					if (rx_tick_cnt == LAST_TICK) begin
						rx_state <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (decide) begin
						rx_shift_register <= {maj, rx_shift_register[7:1]};
						rx_par <= rx_par ^ maj;
						rx_bit_cnt <= rx_bit_cnt + 3'h1;
						if (rx_bit_cnt == ccr.char_length_field) begin
							rx_state <= ccr.mp_mode ? RX_ADDR : (ccr.par_en ? RX_PARITY : RX_STOP);
						end
					end
				end
				RX_ADDR: begin
					if (decide) begin
						rx_addr_bit <= maj;
						rx_par <= rx_par ^ maj;
						rx_state <= ccr.par_en ? RX_PARITY : RX_STOP;
					end
				end
				RX_PARITY: begin
					if (decide) begin
						par_bad <= rx_par ^ maj ^ ~ccr.even;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (decide) begin
						break_cnt <= 7'h00;
						rx_state <= stop_ok ? RX_HUNT : RX_BREAK;
					end
				end
				default: begin
					if (rx_data_pin) begin
						rx_state <= RX_HUNT;
					end else if (break_cnt != 7'(BREAK_TICKS)) begin
						break_cnt <= break_cnt + 7'h01;
					end
				end
			endcase
		end
	end

	// Receive buffer and flags; a hardware set beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buffer <= 8'h00;
			rx_wake_flag <= 1'b0;
		end else if (rx_commit) begin
			rx_buffer <= rx_shift_register >> (3'h7 - ccr.char_length_field);
			rx_wake_flag <= rx_addr_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready_flag <= 1'b0;
		end else if (rx_commit) begin
			rx_ready_flag <= 1'b1;
		end else if (rxbuf_rd) begin
			rx_ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			overrun_flag <= 1'b0;
		end else begin
			framing_error_flag <= (rx_commit && !stop_ok)
				|| (framing_error_flag && !(rxst_wr && pwdata[RXST_FRAMING]));
			parity_error_flag <= (rx_commit && ccr.par_en && par_bad)
				|| (parity_error_flag && !(rxst_wr && pwdata[RXST_PARITY]));
			overrun_flag <= (rx_commit && rx_ready_flag && !rxbuf_rd)
				|| (overrun_flag && !(rxst_wr && pwdata[RXST_OE]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_detect_flag <= 1'b0;
		end else if (baud_tick && rx_state == RX_BREAK && !rx_data_pin && break_cnt == 7'(BREAK_TICKS - 1)
			&& (!sleep_bit || (ccr.mp_mode && rx_addr_bit))) begin
			break_detect_flag <= 1'b1;
		end else if (rxst_wr && pwdata[RXST_BRK]) begin
			break_detect_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt requests and read data
	// ----------------------------------------
	assign rx_irq = (rx_break_irq_enable & (rx_ready_flag | break_detect_flag))
		| (rx_err_irq_enable & rx_error);
	assign tx_irq = tx_irq_enable & tx_ready_flag;
	assign rx_irq_high_pri = rx_hi;
	assign tx_irq_high_pri = tx_hi;
	assign grant_rx = rx_irq & (rx_hi | ~tx_irq | ~tx_hi);
	assign grant_tx = tx_irq & ~grant_rx;

	logic [31:0] read_value;
	always_comb begin
		if (reg_index(paddr) == REG_CCR) begin
			read_value = {24'h000000, ccr};
		end else if (reg_index(paddr) == REG_CTL1) begin
			read_value = {24'h000000, 1'b0, rx_err_irq_enable, 2'h0, tx_wake_request, sleep_bit,
				transmitter_enable_bit, receiver_enable_bit};
		end else if (reg_index(paddr) == REG_HBAUD) begin
			read_value = {24'h000000, baud_hi};
		end else if (reg_index(paddr) == REG_LBAUD) begin
			read_value = {24'h000000, baud_lo};
		end else if (reg_index(paddr) == REG_CTL2) begin
			read_value = {24'h000000, tx_ready_flag, tx_empty, 4'h0, rx_break_irq_enable, tx_irq_enable};
		end else if (reg_index(paddr) == REG_RXST) begin
			read_value = {24'h000000, rx_error, rx_ready_flag, break_detect_flag, framing_error_flag,
				overrun_flag, parity_error_flag, rx_wake_flag, 1'b0};
		end else if (reg_index(paddr) == REG_RXBUF) begin
			read_value = {24'h000000, rx_buffer};
		end else if (reg_index(paddr) == REG_TXBUF) begin
			read_value = {24'h000000, tx_buffer};
		end else if (reg_index(paddr) == REG_PRIO) begin
			read_value = {30'h0, tx_hi, rx_hi};
		end else begin
			read_value = 32'h00000000;
		end
	end

	// Captured in the setup cycle so the access phase sees a flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= read_value;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_wake_to_temp: assert property (
		tx_load && !ctl1_wr |=> !tx_wake_request && wake_temp_flag == $past(tx_wake_request))
		else $error("wake request not moved to temp flag on load");
	a_txbuf_write_ready: assert property (
		txbuf_wr |=> !tx_ready_flag && !tx_empty)
		else $error("tx ready still high after buffer write");
	a_load_sets_ready: assert property (
		tx_load && !txbuf_wr |=> tx_ready_flag && tx_state == TX_START)
		else $error("load did not raise tx ready");
	a_bit_length: assert property (
		tx_state != $past(tx_state) && $past(tx_state) != TX_IDLE |-> $past(tx_bit_end))
		else $error("tx bit ended off the eighth tick");
	a_start_accept: assert property (
		baud_tick && rx_state == RX_HUNT && !rx_data_pin && low_cnt == 2'h3
		|=> rx_state == RX_START && rx_tick_cnt == 3'h4)
		else $error("start not accepted after four low ticks");
	a_start_restart: assert property (
		baud_tick && rx_state == RX_HUNT && rx_data_pin |=> low_cnt == 2'h0 && rx_state == RX_HUNT)
		else $error("high sample did not restart start search");
	a_commit_ready: assert property (
		rx_commit |=> rx_ready_flag && rx_buffer == ($past(rx_shift_register) >> (3'h7 - $past(ccr.char_length_field))))
		else $error("frame not delivered to rx buffer");
	a_read_clears: assert property (
		rxbuf_rd && !rx_commit |=> !rx_ready_flag)
		else $error("rx buffer read left ready set");
	a_rx_disabled: assert property (
		frame_done && !receiver_enable_bit |=> rx_buffer == $past(rx_buffer) && !$rose(rx_ready_flag))
		else $error("disabled receiver updated the buffer");
	a_tx_finish: assert property (
		tx_state != TX_IDLE && !transmitter_enable_bit && !tx_bit_end |=> $stable(tx_state))
		else $error("transmitter stopped mid character");
	a_rx_wins_tie: assert property (
		rx_irq && tx_irq && rx_hi == tx_hi |-> grant_rx && !grant_tx)
		else $error("tx granted over rx at equal priority");
	a_irq_gated: assert property (
		!rx_break_irq_enable && !rx_err_irq_enable |-> !rx_irq)
		else $error("rx request with enables cleared");
	a_sleep_filter: assert property (
		frame_done && sleep_bit && !rx_addr_bit |=> $stable(rx_ready_flag) || !rx_ready_flag)
		else $error("sleeping receiver flagged a data frame");

	c_frame_rx: cover property (rx_commit && ccr.par_en);
	c_address_rx: cover property (rx_commit && rx_addr_bit);
	c_break: cover property (!break_detect_flag ##1 break_detect_flag);
	c_back_to_back: cover property (tx_load ##[1:40] txbuf_wr);
endmodule
`default_nettype wire

//--- design/asp_dummy_unused_marker.sv
// Intentionally holds no code; kept empty to preserve file ordering
`default_nettype none
`default_nettype wire

//--- sim/asp_remote_model.sv
// Remote serial transceiver model on the far side of the line
`default_nettype none
module asp_remote_model (
	// Clock
	input wire logic pclk,
	// Line
	output logic line_out,
	input wire logic line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Divisor 0 acts as 1, so one bit is 8 ticks of 2 clocks
	localparam int BIT = 16;
	logic [9:0] cap = 10'h000;
	int n_got = 0;
	initial line_out = 1'b1;
	task automatic send(input logic [8:0] f, input logic stop_lvl);
		line_out <= 1'b0;
		repeat (BIT) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			line_out <= f[i];
			repeat (BIT) @(posedge pclk);
		end
		line_out <= stop_lvl;
		repeat (stop_lvl ? BIT : 12 * BIT) @(posedge pclk);
		line_out <= 1'b1;
		repeat (BIT) @(posedge pclk);
	endtask
	// Samples mid-bit; stop lands in cap[9]
	initial forever begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge pclk);
			cap[i] = line_in;
		end
		n_got++;
	end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the multiprocessor serial port
`default_nettype none
module tb import asp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, rx_line, tx_line, rx_irq, tx_irq;
	logic rx_hp, tx_hp, grant_rx, grant_tx, slverr_seen;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	asp_serial_port #(.ADDR_W(6)) i_asp_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_data_pin(rx_line), .tx_data_pin(tx_line), .rx_irq(rx_irq), .tx_irq(tx_irq),
		.rx_irq_high_pri(rx_hp), .tx_irq_high_pri(tx_hp), .grant_rx(grant_rx), .grant_tx(grant_tx));
	asp_remote_model i_asp_remote_model (.pclk(pclk), .line_out(rx_line), .line_in(tx_line));
	initial forever #50 pclk = ~pclk;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slverr_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// A hang is cut short well past the longest expected run
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, REG_CCR, 0);
		check("ccr reset", rd, {24'h0, CCR_RESET});
		apb(0, 4'h6, 0);
		check("unmapped read", rd, 32'h0);
		check("unmapped error", 32'(slverr_seen), 32'h1);
		apb(1, REG_CCR, 32'h0F);
		apb(1, REG_CTL2, 32'h03);
		apb(1, REG_CTL1, 32'h0B);
		apb(1, REG_TXBUF, 32'hA5);
		apb(0, REG_CTL1, 0);
		check("wake cleared", rd, 32'h03);
		check("tx irq", 32'(tx_irq), 32'h1);
		apb(1, REG_TXBUF, 32'h3C);
		apb(0, REG_CTL2, 0);
		check("tx ready low", 32'(rd[7]), 32'h0);
		for (int k = 0; k < 2000 && i_asp_remote_model.n_got < 1; k++) @(posedge pclk);
		check("addr frame", 32'(i_asp_remote_model.cap), 32'h3A5);
		for (int k = 0; k < 200 && tx_line !== 1'b0; k++) @(posedge pclk);
		apb(1, REG_CTL1, 32'h01);
		for (int k = 0; k < 2000 && i_asp_remote_model.n_got < 2; k++) @(posedge pclk);
		check("data frame", 32'(i_asp_remote_model.cap), 32'h23C);
		rd = 32'h0;
		for (int k = 0; k < 50 && rd[6] !== 1'b1; k++) apb(0, REG_CTL2, 0);
		check("tx empty", 32'(rd[7:6]), 32'h3);
		$display("transmit test done");
		i_asp_remote_model.send(9'h15A, 1'b1);
		check("rx irq", 32'(rx_irq), 32'h1);
		apb(0, REG_RXST, 0);
		check("rx status", rd, 32'h42);
		apb(0, REG_RXBUF, 0);
		check("rx data", rd, 32'h5A);
		apb(0, REG_RXST, 0);
		check("ready cleared", 32'(rd[6]), 32'h0);
		apb(1, REG_CTL1, 32'h00);
		i_asp_remote_model.send(9'h0C3, 1'b1);
		apb(0, REG_RXBUF, 0);
		check("rx buffer kept", rd, 32'h5A);
		$display("receive test done");
		apb(1, REG_CTL1, 32'h01);
		i_asp_remote_model.send(9'h000, 1'b0);
		apb(0, REG_RXST, 0);
		check("break flags", rd & 32'hB0, 32'hB0);
		check("break irq", 32'(rx_irq), 32'h1);
		$display("break test done");
		check("equal priority grant", 32'({grant_rx, grant_tx}), 32'h2);
		apb(1, REG_PRIO, 32'h02);
		check("tx high priority", 32'({rx_hp, tx_hp, grant_rx, grant_tx}), 32'h5);
		apb(0, REG_RXBUF, 0);
		check("break frame data", rd, 32'h00);
		apb(1, REG_RXST, 32'h3C);
		apb(1, REG_CTL2, 32'h01);
		apb(1, REG_CTL1, 32'h05);
		i_asp_remote_model.send(9'h0AA, 1'b1);
		apb(0, REG_RXST, 0);
		check("sleep data frame", rd, 32'h00);
		i_asp_remote_model.send(9'h1C3, 1'b1);
		apb(0, REG_RXST, 0);
		check("sleep address frame", rd, 32'h42);
		check("rx irq disabled", 32'(rx_irq), 32'h0);
		$display("sleep test done");
		apb(1, REG_CCR, 32'h6E);
		apb(1, REG_CTL1, 32'h0B);
		apb(1, REG_TXBUF, 32'h55);
		for (int k = 0; k < 2000 && i_asp_remote_model.n_got < 3; k++) @(posedge pclk);
		check("parity frame", 32'(i_asp_remote_model.cap), 32'h3D5);
		i_asp_remote_model.send(9'h155, 1'b1);
		apb(0, REG_RXBUF, 0);
		check("seven bit char", rd, 32'h55);
		apb(0, REG_RXST, 0);
		check("parity error", rd & 32'h84, 32'h84);
		$display("parity test done");
		conclude();
	end
endmodule
`default_nettype wire
